// file: logic/flash_pec_defs.svh
// constants for the flash program and erase controller
`ifndef FLASH_PEC_DEFS_SVH
`define FLASH_PEC_DEFS_SVH

// register offsets on the plain register port
`define FPEC_CTRL_ADDR      8'h00
`define FPEC_KEY_ADDR       8'h01
`define FPEC_STAT_ADDR      8'h02
`define FPEC_LOCK_ADDR      8'h03
// control register fields
`define FPEC_CTRL_WE_BIT    0
`define FPEC_CTRL_EE_BIT    1
// status register fields
`define FPEC_STAT_BUSY_BIT  0
`define FPEC_STAT_OPEN_BIT  1
`define FPEC_STAT_LOUT_BIT  2
// key codes
`define FPEC_KEY_FIRST      8'hA5
`define FPEC_KEY_SECOND     8'hF1
// array geometry
`define FPEC_ADDR_BITS      13
`define FPEC_PAGE_BITS      9
`define FPEC_PAGE_LAST      9'h1FF
`define FPEC_RESERVED_BASE  13'h1E00
`define FPEC_LOCK_BYTE_ADDR 13'h1DFF
`define FPEC_LOCK_PAGE      4'hE
`define FPEC_ERASED_BYTE    8'hFF
// timing
`define FPEC_CLK_PERIOD_NS  10
`define FPEC_WRITE_TIME_NS  40000
`define FPEC_ERASE_TIME_NS  10000000
`define FPEC_WRITE_CYCLES   ((`FPEC_WRITE_TIME_NS + `FPEC_CLK_PERIOD_NS - 1) / `FPEC_CLK_PERIOD_NS)
`define FPEC_ERASE_CYCLES   ((`FPEC_ERASE_TIME_NS + `FPEC_CLK_PERIOD_NS - 1) / `FPEC_CLK_PERIOD_NS)

`endif

// file: logic/flash_pec_pkg.sv
// types shared by the flash program and erase controller
package flash_pec_pkg;
    typedef enum logic [3:0] {
        KEY_IDLE    = 4'h1,
        KEY_FIRST   = 4'h2,
        KEY_OPEN    = 4'h4,
        KEY_LOCKOUT = 4'h8
    } key_state_t;
endpackage

// file: logic/flash_key_sequencer.sv
// key unlock sequencer for software flash writes and erases
`timescale 1ns/1ns
`default_nettype none
`include "flash_pec_defs.svh"
module flash_key_sequencer
    import flash_pec_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // key register writes
    input  wire logic       keyWrite,
    input  wire logic [7:0] keyData,
    // software operation attempt (store with write enable set)
    input  wire logic       opAttempt,
    // state
    output key_state_t      keyState,
    output logic            keyOpen,
    output logic            keyLockout
);
    typedef struct packed {
        key_state_t state;
    } seq_t;

    seq_t st_q;
    seq_t st_d;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        case (st_q.state)
            KEY_IDLE: begin
                if (keyWrite) begin
                    st_d.state = (keyData == `FPEC_KEY_FIRST) ? KEY_FIRST : KEY_LOCKOUT;
                end else if (opAttempt) begin
                    st_d.state = KEY_LOCKOUT;
                end
            end
            KEY_FIRST: begin
                if (keyWrite) begin
                    st_d.state = (keyData == `FPEC_KEY_SECOND) ? KEY_OPEN : KEY_LOCKOUT;
                end else if (opAttempt) begin
                    st_d.state = KEY_LOCKOUT;
                end
            end
            KEY_OPEN: begin
                if (opAttempt) begin
                    st_d.state = KEY_IDLE;
                end else if (keyWrite) begin
                    st_d.state = KEY_LOCKOUT;
                end
            end
            KEY_LOCKOUT: begin
                st_d.state = KEY_LOCKOUT;
            end
            default: begin
                st_d.state = KEY_LOCKOUT;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '{state: KEY_IDLE};
        end else begin
            st_q <= st_d;
        end
    end

    // decoded outputs
    assign keyState   = st_q.state;
    assign keyOpen    = (st_q.state == KEY_OPEN);
    assign keyLockout = (st_q.state == KEY_LOCKOUT);
endmodule
`default_nettype wire

// file: logic/flash_op_timer.sv
// self-timed duration counter for flash writes and erases
`timescale 1ns/1ns
`default_nettype none
module flash_op_timer #(
    parameter int CNT_W = 20
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // start with a cycle count
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load,
    // progress
    output logic                  busy,
    output logic                  done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             busy;
        logic             done;
    } tmr_t;

    tmr_t st_q;
    tmr_t st_d;

    // count down while busy, one-cycle done at the end
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (start && !st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.cnt  = load;
        end else if (st_q.busy) begin
            if (st_q.cnt <= CNT_W'(1)) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = st_q.busy;
    assign done = st_q.done;
endmodule
`default_nettype wire

// file: logic/flash_program_erase_control.sv
// flash program and erase controller with key lock and page protection
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "flash_pec_defs.svh"

////////////////////////////////////////////////////////////////////////
module flash_program_erase_control
    import flash_pec_pkg::*;
#(
    parameter int ERASE_CYCLES = `FPEC_ERASE_CYCLES,
    parameter int CNT_W        = 20
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    // processor external-space stores and code-space reads
    input  wire logic       storeWrite,
    input  wire logic [12:0] storeAddr,
    input  wire logic [7:0] storeData,
    input  wire logic [12:0] execPc,
    input  wire logic       codeRead,
    input  wire logic [12:0] codeAddr,
    output logic      [7:0] codeRdata,
    output logic            xramWrite,
    output logic            cpuStall,
    output logic            flashErrorReset,
    // debug programming interface
    input  wire logic       dbgWrite,
    input  wire logic       dbgErase,
    input  wire logic       dbgRead,
    input  wire logic [12:0] dbgAddr,
    input  wire logic [7:0] dbgData,
    output logic      [7:0] dbgRdata,
    output logic            dbgBusy
);
    typedef struct packed {
        logic        wrEn;
        logic        erEn;
        logic [7:0]  lockByte;
        logic        lockLoaded;
        logic [12:0] opAddr;
        logic        opErase;
        logic [8:0]  sweepIdx;
        logic        sweeping;
        logic        errPulse;
        logic [7:0]  regRdata;
        logic [7:0]  codeRdata;
        logic [7:0]  dbgRdata;
        logic [CNT_W-1:0] busyCnt;
    } ctl_t;

    ctl_t        st_q;
    ctl_t        st_d;
    logic [7:0]  flashMem [0:(1 << `FPEC_ADDR_BITS) - 1];
    logic        memWrEn;
    logic [12:0] memAddr;
    logic [7:0]  memData;
    logic        keyWrite;
    logic        swStore;
    logic        swForbid;
    logic        swAttempt;
    logic        swStart;
    logic        dbgReq;
    logic        dbgForbid;
    logic        dbgStart;
    logic        opStart;
    logic [12:0] srcAddr;
    logic [7:0]  srcData;
    logic        srcErase;
    logic [7:0]  oldByte;
    logic        codeForbid;
    logic        tBusy;
    logic        tDone;
    logic        keyOpen;
    logic        keyLockout;
    key_state_t  keyState;
    logic [CNT_W-1:0] tLoad;

    ////////////////////////////////////////////////////////////////////
    // protection decode
    function automatic logic reservedArea(input logic [12:0] a);
        return a >= `FPEC_RESERVED_BASE;
    endfunction

    function automatic logic pageLocked(input logic [12:0] a, input logic [7:0] lb);
        logic [7:0] n;
        logic [3:0] pg;
        n  = ~lb;
        pg = a[12:9];
        return ({4'h0, pg} < n) || ((pg == `FPEC_LOCK_PAGE) && (n != 8'h00));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // request decode
    assign keyWrite  = regWrite && (regAddr == `FPEC_KEY_ADDR);
    assign swStore   = storeWrite && st_q.wrEn && !tBusy && st_q.lockLoaded;
    // locked target from unlocked code, reserved area, lock page erase, lock byte rewrite
    assign swForbid  = reservedArea(storeAddr)
                    || (pageLocked(storeAddr, st_q.lockByte)
                        && !pageLocked(execPc, st_q.lockByte))
                    || (st_q.erEn && (storeAddr[12:9] == `FPEC_LOCK_PAGE))
                    || ((storeAddr == `FPEC_LOCK_BYTE_ADDR) && (st_q.lockByte != 8'hFF));
    assign swAttempt = swStore && !swForbid;
    assign swStart   = swAttempt && keyOpen;
    // debug needs no keys, so a blank device can still be programmed
    assign dbgReq    = (dbgWrite || dbgErase) && !tBusy && st_q.lockLoaded && !swStore;
    assign dbgForbid = reservedArea(dbgAddr) || pageLocked(dbgAddr, st_q.lockByte);
    assign dbgStart  = dbgReq && !dbgForbid;
    assign opStart   = swStart || dbgStart;
    assign srcAddr   = swStart ? storeAddr : dbgAddr;
    assign srcData   = swStart ? storeData : dbgData;
    assign srcErase  = swStart ? st_q.erEn : dbgErase;
    assign oldByte   = flashMem[srcAddr];
    assign codeForbid = reservedArea(codeAddr)
                     || (pageLocked(codeAddr, st_q.lockByte)
                         && !pageLocked(execPc, st_q.lockByte));
    assign tLoad     = srcErase ? CNT_W'(ERASE_CYCLES) : CNT_W'(`FPEC_WRITE_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // key sequencer and operation timer
    flash_key_sequencer u_keys (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .keyWrite   (keyWrite),
        .keyData    (regWdata),
        .opAttempt  (swAttempt),
        .keyState   (keyState),
        .keyOpen    (keyOpen),
        .keyLockout (keyLockout)
    );

    flash_op_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (opStart),
        .load    (tLoad),
        .busy    (tBusy),
        .done    (tDone)
    );

    ////////////////////////////////////////////////////////////////////
    // array write port: byte program at start, page sweep during erase
    always_comb begin
        memWrEn = 1'b0;
        memAddr = srcAddr;
        memData = oldByte & srcData;
        if (opStart && !srcErase) begin
            memWrEn = 1'b1;
        end else if (st_q.sweeping) begin
            memWrEn = 1'b1;
            memAddr = {st_q.opAddr[12:9], st_q.sweepIdx};
            memData = `FPEC_ERASED_BYTE;
        end
    end

    // non-volatile array, never reset
    always_ff @(posedge ref_clk) begin
        if (memWrEn) begin
            flashMem[memAddr] <= memData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control next state
    always_comb begin
        st_d          = st_q;
        st_d.errPulse = 1'b0;
        // lock byte captured once after reset release
        if (!st_q.lockLoaded) begin
            st_d.lockByte   = flashMem[`FPEC_LOCK_BYTE_ADDR];
            st_d.lockLoaded = 1'b1;
        end
        // control register
        if (regWrite && (regAddr == `FPEC_CTRL_ADDR)) begin
            st_d.wrEn = regWdata[`FPEC_CTRL_WE_BIT];
            st_d.erEn = regWdata[`FPEC_CTRL_EE_BIT];
        end
        // read data for the next cycle
        st_d.regRdata = 8'h00;
        if (regRead) begin
            case (regAddr)
                `FPEC_CTRL_ADDR: begin
                    st_d.regRdata = {6'h00, st_q.erEn, st_q.wrEn};
                end
                `FPEC_STAT_ADDR: begin
                    st_d.regRdata = {5'h00, keyLockout, keyOpen, tBusy};
                end
                `FPEC_LOCK_ADDR: begin
                    st_d.regRdata = st_q.lockByte;
                end
                default: begin
                    st_d.regRdata = 8'h00;
                end
            endcase
        end
        // forbidden software store
        if (swStore && swForbid) begin
            st_d.errPulse = 1'b1;
        end
        // code-space reads of the array
        if (codeRead) begin
            st_d.codeRdata = codeForbid ? 8'h00 : flashMem[codeAddr];
            if (codeForbid) begin
                st_d.errPulse = 1'b1;
            end
        end
        // debug reads, forbidden ones return zero
        if (dbgRead) begin
            st_d.dbgRdata = dbgForbid ? 8'h00 : flashMem[dbgAddr];
        end
        // operation start
        if (opStart) begin
            st_d.opAddr  = srcAddr;
            st_d.opErase = srcErase;
            if (srcErase) begin
                st_d.sweeping = 1'b1;
                st_d.sweepIdx = 9'h000;
            end
        end
        // erase sweep across the page
        if (st_q.sweeping) begin
            st_d.sweepIdx = st_q.sweepIdx + 9'h001;
            if (st_q.sweepIdx == `FPEC_PAGE_LAST) begin
                st_d.sweeping = 1'b0;
            end
        end
        // checker helper: busy cycles since the last start
        if (opStart) begin
            st_d.busyCnt = '0;
        end else if (tBusy) begin
            st_d.busyCnt = st_q.busyCnt + CNT_W'(1);
        end
    end

    // control register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign regRdata        = st_q.regRdata;
    assign codeRdata       = st_q.codeRdata;
    assign dbgRdata        = st_q.dbgRdata;
    assign flashErrorReset = st_q.errPulse;
    assign cpuStall        = tBusy || !st_q.lockLoaded;
    assign dbgBusy         = tBusy || !st_q.lockLoaded;
    assign xramWrite       = storeWrite && !st_q.wrEn;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    property p_stall_during_op;
        opStart |=> cpuStall [*8];
    endproperty
    a_stall_during_op: assert property (p_stall_during_op) else $error("stall dropped");

    property p_write_timed;
        (tDone && !st_q.opErase) |-> (st_q.busyCnt == CNT_W'(`FPEC_WRITE_CYCLES));
    endproperty
    a_write_timed: assert property (p_write_timed) else $error("write not timed");

    property p_clear_only;
        (opStart && !srcErase) |=> ((flashMem[st_q.opAddr] & ~$past(oldByte)) == 8'h00);
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("write set a bit");

    property p_relock;
        swStart |=> !keyOpen;
    endproperty
    a_relock: assert property (p_relock) else $error("key not relocked");

    property p_lockout_sticky;
        keyLockout |=> keyLockout;
    endproperty
    a_lockout_sticky: assert property (p_lockout_sticky) else $error("lockout left");

    property p_bad_first_key;
        (keyWrite && (keyState == KEY_IDLE) && (regWdata != `FPEC_KEY_FIRST)) |=> keyLockout;
    endproperty
    a_bad_first_key: assert property (p_bad_first_key) else $error("bad key accepted");

    property p_early_store;
        (swAttempt && !keyOpen) |=> keyLockout && !tBusy;
    endproperty
    a_early_store: assert property (p_early_store) else $error("early store ran");

    property p_erase_fill;
        (tDone && st_q.opErase) |-> (flashMem[{st_q.opAddr[12:9], 9'h1FF}] == 8'hFF);
    endproperty
    a_erase_fill: assert property (p_erase_fill) else $error("page not erased");

    property p_forbid_error;
        (swStore && swForbid) |=> flashErrorReset ##1 !flashErrorReset;
    endproperty
    a_forbid_error: assert property (p_forbid_error) else $error("no error reset");

    property p_dbg_ignore;
        (dbgReq && dbgForbid && !codeRead) |=> !flashErrorReset && !tBusy;
    endproperty
    a_dbg_ignore: assert property (p_dbg_ignore) else $error("debug not ignored");

    property p_store_route;
        (storeWrite && !st_q.wrEn) |-> xramWrite && !swStart;
    endproperty
    a_store_route: assert property (p_store_route) else $error("store misrouted");

    c_sw_write: cover property (swStart && !srcErase);
    c_sw_erase: cover property (swStart && srcErase);
    c_lockout: cover property ($rose(keyLockout));
    c_error: cover property (flashErrorReset);
endmodule
`default_nettype wire

// file: tb/cpu_store_model.sv
// processor-side store model for the flash program and erase controller
`timescale 1ns/1ns
`default_nettype none
module cpu_store_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // store request from the bench
    input  wire logic        go,
    input  wire logic [12:0] goAddr,
    input  wire logic [7:0]  goData,
    // stall from the flash controller
    input  wire logic        cpuStall,
    // external-space store cycle
    output logic             storeWrite,
    output logic      [12:0] storeAddr,
    output logic      [7:0]  storeData
);
    logic        pend_q;
    logic [12:0] addr_q;
    logic [7:0]  data_q;

    ////////////////////////////////////////////////////////////////////////
    // defined levels before the first edge
    initial begin
        storeWrite = 1'b0;
        storeAddr  = 13'h0000;
        storeData  = 8'h00;
        pend_q     = 1'b0;
    end

    // one store per request, held back while the core is stalled
    always @(posedge ref_clk) begin
        storeWrite <= 1'b0;
        storeAddr  <= ~storeAddr;   // idle lines keep moving
        storeData  <= ~storeData;
        if (reset) begin
            pend_q <= 1'b0;
        end else if (go) begin
            pend_q <= 1'b1;
            addr_q <= goAddr;
            data_q <= goData;
        end else if (pend_q && !cpuStall) begin
            pend_q     <= 1'b0;
            storeWrite <= 1'b1;
            storeAddr  <= addr_q;
            storeData  <= data_q;
        end
    end
endmodule
`default_nettype wire

// file: tb/flash_program_erase_control_tb_top.sv
// self-checking bench for the flash program and erase controller
`timescale 1ns/1ns
`default_nettype none
`include "flash_pec_defs.svh"
module flash_program_erase_control_tb_top;
    localparam int EC = 600;
    logic        ref_clk, reset, regWrite, regRead, storeWrite, codeRead, xramWrite;
    logic        cpuStall, flashErrorReset, dbgWrite, dbgErase, dbgRead, dbgBusy, go, xwSeen;
    logic [7:0]  regAddr, regWdata, regRdata, storeData, codeRdata, dbgData, dbgRdata;
    logic [7:0]  goData, d1, d2;
    logic [12:0] storeAddr, execPc, codeAddr, dbgAddr, goAddr, a;
    logic [15:0] seed;
    int          mismatches, n_compared, n;

    ////////////////////////////////////////////////////////////////////////
    // device and processor model
    flash_program_erase_control #(.ERASE_CYCLES(EC), .CNT_W(20)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .storeWrite(storeWrite), .storeAddr(storeAddr), .storeData(storeData),
        .execPc(execPc), .codeRead(codeRead), .codeAddr(codeAddr), .codeRdata(codeRdata),
        .xramWrite(xramWrite), .cpuStall(cpuStall), .flashErrorReset(flashErrorReset),
        .dbgWrite(dbgWrite), .dbgErase(dbgErase), .dbgRead(dbgRead), .dbgAddr(dbgAddr),
        .dbgData(dbgData), .dbgRdata(dbgRdata), .dbgBusy(dbgBusy));
    cpu_store_model i_cpu (
        .ref_clk(ref_clk), .reset(reset), .go(go), .goAddr(goAddr), .goData(goData),
        .cpuStall(cpuStall), .storeWrite(storeWrite), .storeAddr(storeAddr),
        .storeData(storeData));

    // clock, 10 ns period
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    // random source and checking helpers
    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic inr(int v, int t);
        return (v >= t - 5) && (v <= t + 5);
    endfunction
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bus tasks, each entered and left just after a rising edge
    task automatic reg_wr(logic [7:0] ad, logic [7:0] d);
        regWrite <= 1'b1;
        regAddr  <= ad;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic reg_rd(logic [7:0] ad, logic [7:0] exp, string nm);
        regRead <= 1'b1;
        regAddr <= ad;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(nm, regRdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic keys();
        reg_wr(`FPEC_KEY_ADDR, `FPEC_KEY_FIRST);
        reg_wr(`FPEC_KEY_ADDR, `FPEC_KEY_SECOND);
    endtask
    task automatic rd(logic dbg, logic [12:0] ad, logic [7:0] exp, logic err, string nm);
        if (dbg) begin
            dbgRead <= 1'b1;
            dbgAddr <= ad;
        end else begin
            codeRead <= 1'b1;
            codeAddr <= ad;
        end
        @(posedge ref_clk);
        dbgRead  <= 1'b0;
        codeRead <= 1'b0;
        #1;
        chk(nm, dbg ? dbgRdata : codeRdata, exp);
        chk("errReset", flashErrorReset, err);
        @(posedge ref_clk);
    endtask
    task automatic wait_idle();
        n = 0;
        while (cpuStall !== 1'b0 && n < 20000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    // store through the core model; ends just after the taking edge
    task automatic sw_store(logic [12:0] ad, logic [7:0] d);
        goAddr <= ad;
        goData <= d;
        go     <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        #1;
        xwSeen = xramWrite;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic dbg_op(logic er, logic [12:0] ad, logic [7:0] d);
        dbgErase <= er;
        dbgWrite <= !er;
        dbgAddr  <= ad;
        dbgData  <= d;
        @(posedge ref_clk);
        dbgErase <= 1'b0;
        dbgWrite <= 1'b0;
        #1;
        chk("dbgBusy", dbgBusy, 1'b1);
        wait_idle();
        chk("dbgTime", inr(n, er ? EC : `FPEC_WRITE_CYCLES), 1'b1);
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        #400000;
        mismatches++;
        wrap_up();
    end

    // main sequence
    initial begin
        {reset, regWrite, regRead, codeRead, dbgWrite, dbgErase, dbgRead, go} = 8'h80;
        {regAddr, regWdata, dbgData, goData} = 32'h0;
        {codeAddr, dbgAddr, goAddr} = 39'h0;
        execPc = 13'h0800;
        seed = 16'h9F5D;
        // blank device: the whole array starts erased
        for (int i = 0; i < (1 << `FPEC_ADDR_BITS); i++) begin
            i_dut.flashMem[i] = `FPEC_ERASED_BYTE;
        end
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        reg_rd(`FPEC_CTRL_ADDR, 8'h00, "ctrl");
        reg_rd(`FPEC_STAT_ADDR, 8'h00, "status");
        reg_rd(`FPEC_LOCK_ADDR, 8'hFF, "lockByte");
        reg_rd(8'h7F, 8'h00, "unmapped");
        // write enable clear: the store goes to external RAM
        seed = nxt(seed);
        sw_store(seed[12:0], seed[7:0]);
        chk("xramWrite", xwSeen, 1'b1);
        chk("stallOff", cpuStall, 1'b0);
        // page erase of page 1
        reg_wr(`FPEC_CTRL_ADDR, 8'h03);
        keys();
        reg_rd(`FPEC_STAT_ADDR, 8'h02, "keysOpen");
        seed = nxt(seed);
        sw_store({4'h1, seed[8:0]}, seed[15:8]);
        chk("xramOff", xwSeen, 1'b0);
        chk("eraseStall", cpuStall, 1'b1);
        wait_idle();
        chk("eraseTime", inr(n, EC), 1'b1);
        reg_rd(`FPEC_STAT_ADDR, 8'h00, "relock");
        rd(1'b0, 13'h0200, 8'hFF, 1'b0, "erasedLow");
        rd(1'b0, 13'h03FF, 8'hFF, 1'b0, "erasedHigh");
        // two byte writes to one place: bits only clear
        reg_wr(`FPEC_CTRL_ADDR, 8'h01);
        seed = nxt(seed);
        a  = {4'h1, seed[8:0]};
        d1 = seed[15:8];
        seed = nxt(seed);
        d2 = seed[7:0];
        for (int i = 0; i < 2; i++) begin
            keys();
            sw_store(a, i ? d2 : d1);
            chk("writeStall", cpuStall, 1'b1);
            wait_idle();
            chk("writeTime", inr(n, `FPEC_WRITE_CYCLES), 1'b1);
        end
        rd(1'b0, a, d1 & d2, 1'b0, "andWrite");
        // store with keys closed locks out until reset
        sw_store(a, 8'h00);
        chk("noOp", cpuStall, 1'b0);
        reg_rd(`FPEC_STAT_ADDR, 8'h04, "lockout");
        keys();
        sw_store(a, 8'h00);
        chk("stillLocked", cpuStall, 1'b0);
        rd(1'b0, a, d1 & d2, 1'b0, "unchanged");
        // wrong value, then wrong order
        for (int i = 0; i < 2; i++) begin
            do_reset();
            reg_rd(`FPEC_STAT_ADDR, 8'h00, "resetClears");
            reg_wr(`FPEC_KEY_ADDR, i ? `FPEC_KEY_SECOND : `FPEC_KEY_FIRST);
            reg_wr(`FPEC_KEY_ADDR, i ? `FPEC_KEY_FIRST : 8'h5A);
            reg_rd(`FPEC_STAT_ADDR, 8'h04, "badKeys");
        end
        // reserved area store asks for an error reset
        do_reset();
        reg_wr(`FPEC_CTRL_ADDR, 8'h01);
        keys();
        seed = nxt(seed);
        sw_store({4'hF, seed[8:0]}, 8'h00);
        chk("reservedErr", flashErrorReset, 1'b1);
        chk("reservedNoOp", cpuStall, 1'b0);
        // debug path: erase, write, read back, reserved read ignored
        seed = nxt(seed);
        a = {4'h2, seed[8:0]};
        dbg_op(1'b1, a, 8'h00);
        dbg_op(1'b0, a, seed[15:8]);
        rd(1'b1, a, seed[15:8], 1'b0, "dbgData");
        rd(1'b1, 13'h1E10, 8'h00, 1'b0, "dbgReserved");
        // lock page 0 through the lock byte
        dbg_op(1'b0, `FPEC_LOCK_BYTE_ADDR, 8'hFE);
        reg_rd(`FPEC_LOCK_ADDR, 8'hFF, "lockDeferred");
        do_reset();
        reg_rd(`FPEC_LOCK_ADDR, 8'hFE, "lockInEffect");
        rd(1'b1, 13'h0010, 8'h00, 1'b0, "dbgLocked");
        rd(1'b1, 13'h1D00, 8'h00, 1'b0, "dbgLockPage");
        // forbidden debug write: no operation, no error reset
        dbgWrite <= 1'b1;
        dbgAddr  <= 13'h0010;
        @(posedge ref_clk);
        dbgWrite <= 1'b0;
        #1;
        chk("dbgIgnored", dbgBusy, 1'b0);
        chk("dbgNoErr", flashErrorReset, 1'b0);
        @(posedge ref_clk);
        rd(1'b0, 13'h0010, 8'h00, 1'b1, "codeLocked");
        execPc <= 13'h0000;
        rd(1'b0, `FPEC_LOCK_BYTE_ADDR, 8'hFE, 1'b0, "lockedCaller");
        wrap_up();
    end
endmodule
`default_nettype wire
